// File: hdl/ccd_pkg.sv
// Constants and types of the coil current driver register bank.
// Assumes a 20 MHz system clock and a two-wire serial link clocked by its master.
package ccd_pkg;
  localparam logic [7:0] ADDR_SYS_CTL = 8'h02;
  localparam logic [7:0] ADDR_CUR_HIGH = 8'h03;
  localparam logic [7:0] ADDR_CUR_LOW = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h05;
  localparam logic [7:0] ADDR_MODE = 8'h06;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam int BIT_SOFT_RESET = 0;
  localparam int BIT_FAULT_CHECK_TRIGGER = 5;
  localparam int BIT_OVERTEMP = 4;
  localparam int BIT_SHORT = 3;
  localparam int BIT_OPEN = 2;
  localparam int BIT_OVERCURRENT = 0;
  localparam int BIT_RETRY = 7;
  localparam int CUR_HIGH_MSB = 1;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] CUR_HIGH_MASK = 8'h03;
  localparam logic [7:0] SOFT_RESET_MASK = 8'h01;
  localparam logic [9:0] CUR_ZERO = 10'h000;
  localparam logic [9:0] CUR_FULL_SCALE = 10'h3ff;
  localparam int CUR_LSB_NA = 97700;
  localparam int CLK_FREQ_HZ = 20000000;
  localparam int FAULT_CHECK_TRIGGER_TIME_MS = 1;
  localparam int RETRY_TIME_MS = 100;
  localparam int FAULT_CHECK_TRIGGER_CYCLES = CLK_FREQ_HZ / 1000 * FAULT_CHECK_TRIGGER_TIME_MS;
  localparam int RETRY_CYCLES = CLK_FREQ_HZ / 1000 * RETRY_TIME_MS;
  // Arbitrary default link address
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h0c;
  localparam logic [3:0] BIT_FIRST = 4'h1;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  typedef enum logic [2:0] {LINK_IDLE, LINK_ADDR, LINK_REG, LINK_WRITE, LINK_READ} ccd_link_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic commit;
  } ccd_wr_t;

  typedef struct packed {
    logic wrTog;
    logic overcurrent;
    logic overtemp;
    logic shorted;
    logic open;
  } ccd_sense_t;

  typedef struct packed {
    logic [7:0] sysCtl;
    logic [7:0] curHigh;
    logic [7:0] curLow;
    logic [7:0] status;
    logic [7:0] mode;
  } ccd_image_t;

  function automatic logic [7:0] ccd_read_reg(input ccd_image_t img, input logic [7:0] addr);
    case (addr)
      ADDR_SYS_CTL: ccd_read_reg = img.sysCtl;
      ADDR_CUR_HIGH: ccd_read_reg = img.curHigh;
      ADDR_CUR_LOW: ccd_read_reg = img.curLow;
      ADDR_STATUS: ccd_read_reg = img.status;
      ADDR_MODE: ccd_read_reg = img.mode;
      default: ccd_read_reg = REG_RESET;
    endcase
  endfunction
endpackage

// File: hdl/ccd_sync.sv
// Three-stage synchroniser for a group of asynchronous levels.
// A bit changes at the output once stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module ccd_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1_reg, stage2_reg, stage3_reg, out_reg;
  logic [WIDTH-1:0] out_next;

  always_comb begin
    out_next = (stage2_reg & stage3_reg) | (out_reg & (stage2_reg ^ stage3_reg));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
      out_reg <= '0;
    end else begin
      stage1_reg <= din;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      out_reg <= out_next;
    end
  end

  assign dout = out_reg;
endmodule
`default_nettype wire

// File: hdl/ccd_regs.sv
// Register bank and protection logic of the coil current driver.
// Link side runs on the serial clock; registers and protection on clk.
`timescale 1ns/1ns
`default_nettype none
module ccd_regs import ccd_pkg::*; #(
  parameter int FAULT_CHECK_TRIGGER_COUNT = FAULT_CHECK_TRIGGER_CYCLES,
  parameter int RETRY_COUNT = RETRY_CYCLES,
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic linkClk,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic overcurrentSense,
  input wire logic overtempSense,
  input wire logic shortSense,
  input wire logic openSense,
  output logic [9:0] coilCurrent,
  output logic driveOutPosEn,
  output logic driveOutNegEn,
  output logic standby,
  output logic diagRun
);
  localparam int DW = $clog2(FAULT_CHECK_TRIGGER_COUNT + 1);
  localparam int RW = $clog2(RETRY_COUNT + 1);
  localparam logic [DW-1:0] FAULT_CHECK_TRIGGER_END = DW'(FAULT_CHECK_TRIGGER_COUNT);
  localparam logic [RW-1:0] RETRY_END = RW'(RETRY_COUNT - 1);

  // ---------------- Link domain ----------------
  logic startTog_reg, startTog_next;
  ccd_link_t linkState_reg, linkState_next;
  logic [3:0] bitCnt_reg, bitCnt_next;
  logic [6:0] shift_reg, shift_next;
  logic [7:0] ptr_reg, ptr_next;
  logic [7:0] txByte_reg, txByte_next;
  logic hiSeen_reg, hiSeen_next;
  logic ackNow_reg, ackNow_next;
  logic startSeen_reg, startSeen_next;
  logic wrTog_reg, wrTog_next;
  ccd_wr_t wrReq_reg, wrReq_next;
  ccd_image_t image_reg, image_next;
  ccd_image_t img1_reg, img2_reg, img3_reg, imgUse_reg, imgUse_next;
  logic sdaOe_reg, sdaOe_next, sdaOut_reg;
  logic [7:0] byteIn;

  // Start seen as falling data while the serial clock is high
  always_comb begin
    startTog_next = startTog_reg;
    if (linkClk) begin
      startTog_next = ~startTog_reg;
    end
  end

  always_ff @(negedge sdaIn or posedge rst) begin
    if (rst) begin
      startTog_reg <= 1'b0;
    end else begin
      startTog_reg <= startTog_next;
    end
  end

  // Byte engine; start toggle settles for half a clock before use
  always_comb begin
    byteIn = {shift_reg, sdaIn};
    linkState_next = linkState_reg;
    bitCnt_next = bitCnt_reg + 4'h1;
    shift_next = byteIn[6:0];
    ptr_next = ptr_reg;
    txByte_next = txByte_reg;
    hiSeen_next = hiSeen_reg;
    ackNow_next = 1'b0;
    startSeen_next = startTog_reg;
    wrTog_next = wrTog_reg;
    wrReq_next = wrReq_reg;
    imgUse_next = (img2_reg == img3_reg) ? img3_reg : imgUse_reg;
    if (startTog_reg != startSeen_reg) begin
      linkState_next = LINK_ADDR;
      bitCnt_next = BIT_FIRST;
      hiSeen_next = 1'b0;
    end else if (bitCnt_reg == ACK_SLOT) begin
      bitCnt_next = '0;
      if (linkState_reg == LINK_READ && !ackNow_reg) begin
        if (sdaIn) begin
          linkState_next = LINK_IDLE;
        end else begin
          ptr_next = ptr_reg + PTR_STEP;
          txByte_next = ccd_read_reg(imgUse_reg, ptr_reg + PTR_STEP);
        end
      end
    end else if (bitCnt_reg == BIT_LAST) begin
      case (linkState_reg)
        LINK_ADDR: begin
          if (byteIn[7:1] == DEV_ADDR) begin
            ackNow_next = 1'b1;
            if (byteIn[0]) begin
              linkState_next = LINK_READ;
              txByte_next = ccd_read_reg(imgUse_reg, ptr_reg);
            end else begin
              linkState_next = LINK_REG;
            end
          end else begin
            linkState_next = LINK_IDLE;
          end
        end
        LINK_REG: begin
          ackNow_next = 1'b1;
          ptr_next = byteIn;
          hiSeen_next = 1'b0;
          linkState_next = LINK_WRITE;
        end
        LINK_WRITE: begin
          ackNow_next = 1'b1;
          wrReq_next.addr = ptr_reg;
          wrReq_next.data = byteIn;
          wrReq_next.commit = (ptr_reg == ADDR_CUR_LOW) && hiSeen_reg;
          wrTog_next = ~wrTog_reg;
          if (ptr_reg == ADDR_CUR_HIGH) begin
            hiSeen_next = 1'b1;
          end
          ptr_next = ptr_reg + PTR_STEP;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      linkState_reg <= LINK_IDLE;
      bitCnt_reg <= '0;
      shift_reg <= '0;
      ptr_reg <= REG_RESET;
      txByte_reg <= REG_RESET;
      hiSeen_reg <= 1'b0;
      ackNow_reg <= 1'b0;
      startSeen_reg <= 1'b0;
      wrTog_reg <= 1'b0;
      wrReq_reg <= '0;
      img1_reg <= '0;
      img2_reg <= '0;
      img3_reg <= '0;
      imgUse_reg <= '0;
    end else begin
      linkState_reg <= linkState_next;
      bitCnt_reg <= bitCnt_next;
      shift_reg <= shift_next;
      ptr_reg <= ptr_next;
      txByte_reg <= txByte_next;
      hiSeen_reg <= hiSeen_next;
      ackNow_reg <= ackNow_next;
      startSeen_reg <= startSeen_next;
      wrTog_reg <= wrTog_next;
      wrReq_reg <= wrReq_next;
      img1_reg <= image_reg;
      img2_reg <= img1_reg;
      img3_reg <= img2_reg;
      imgUse_reg <= imgUse_next;
    end
  end

  // Data changes while the serial clock is low
  always_comb begin
    sdaOe_next = ackNow_reg;
    if (linkState_reg == LINK_READ && bitCnt_reg < ACK_SLOT) begin
      sdaOe_next = !txByte_reg[3'(BIT_LAST - bitCnt_reg)];
    end
  end

  always_ff @(negedge linkClk or posedge rst) begin
    if (rst) begin
      sdaOe_reg <= 1'b0;
      sdaOut_reg <= 1'b0;
    end else begin
      sdaOe_reg <= sdaOe_next;
      sdaOut_reg <= 1'b0;
    end
  end

  assign sdaOe = sdaOe_reg;
  assign sdaOut = sdaOut_reg;

  // ---------------- System domain ----------------
  ccd_sense_t senseIn, sense;
  logic wrSeen_reg, wrSeen_next;
  logic [7:0] sysCtl_reg, sysCtl_next;
  logic [7:0] curHigh_reg, curHigh_next;
  logic [7:0] curLow_reg, curLow_next;
  logic [7:0] mode_reg, mode_next;
  logic fault_check_trigger_reg, fault_check_trigger_next;
  logic shortFlag_reg, shortFlag_next;
  logic openFlag_reg, openFlag_next;
  logic overtempFlag_reg, overtempFlag_next;
  logic overcurrentFlag_reg, overcurrentFlag_next;
  logic [DW-1:0] diagCnt_reg, diagCnt_next;
  logic [RW-1:0] retryCnt_reg, retryCnt_next;
  logic [9:0] coilCurrent_reg, coilCurrent_next;
  logic driveEn_reg, driveEn_next;
  logic standby_reg, standby_next;
  logic wrApply, softReset;

  assign senseIn = '{wrTog: wrTog_reg, overcurrent: overcurrentSense, overtemp: overtempSense,
                     shorted: shortSense, open: openSense};

  ccd_sync #(.WIDTH($bits(ccd_sense_t))) u_sync (
    .clk(clk),
    .rst(rst),
    .din(senseIn),
    .dout(sense)
  );

  always_comb begin
    wrSeen_next = sense.wrTog;
    wrApply = sense.wrTog != wrSeen_reg;
    softReset = wrApply && wrReq_reg.addr == ADDR_SYS_CTL && wrReq_reg.data[BIT_SOFT_RESET];
    sysCtl_next = sysCtl_reg;
    curHigh_next = curHigh_reg;
    curLow_next = curLow_reg;
    mode_next = mode_reg;
    fault_check_trigger_next = fault_check_trigger_reg;
    diagCnt_next = diagCnt_reg;
    retryCnt_next = retryCnt_reg;
    coilCurrent_next = coilCurrent_reg;
    overcurrentFlag_next = overcurrentFlag_reg;
    overtempFlag_next = sense.overtemp;
    if (wrApply) begin
      case (wrReq_reg.addr)
        ADDR_SYS_CTL: sysCtl_next = wrReq_reg.data;
        ADDR_CUR_HIGH: curHigh_next = wrReq_reg.data & CUR_HIGH_MASK;
        ADDR_CUR_LOW: begin
          curLow_next = wrReq_reg.data;
          if (wrReq_reg.commit) begin
            coilCurrent_next = {curHigh_reg[CUR_HIGH_MSB:0], wrReq_reg.data};
          end
        end
        ADDR_STATUS: begin
          fault_check_trigger_next = wrReq_reg.data[BIT_FAULT_CHECK_TRIGGER];
          if (!fault_check_trigger_reg) begin
            diagCnt_next = '0;
          end
        end
        ADDR_MODE: mode_next = wrReq_reg.data;
        default: begin
        end
      endcase
    end
    if (fault_check_trigger_reg && diagCnt_reg != FAULT_CHECK_TRIGGER_END) begin
      diagCnt_next = diagCnt_reg + 1'b1;
    end
    if (!overcurrentFlag_reg) begin
      if (sense.overcurrent && coilCurrent_reg != CUR_ZERO) begin
        overcurrentFlag_next = 1'b1;
        retryCnt_next = '0;
      end
    end else if (coilCurrent_reg == CUR_ZERO) begin
      overcurrentFlag_next = 1'b0;
    end else if (mode_reg[BIT_RETRY]) begin
      if (retryCnt_reg == RETRY_END) begin
        retryCnt_next = '0;
        overcurrentFlag_next = sense.overcurrent;
      end else begin
        retryCnt_next = retryCnt_reg + 1'b1;
      end
    end
    if (softReset) begin
      sysCtl_next = wrReq_reg.data & SOFT_RESET_MASK;
      curHigh_next = REG_RESET;
      curLow_next = REG_RESET;
      mode_next = REG_RESET;
      fault_check_trigger_next = 1'b0;
      diagCnt_next = '0;
      retryCnt_next = '0;
      coilCurrent_next = CUR_ZERO;
      overcurrentFlag_next = 1'b0;
    end
    shortFlag_next = fault_check_trigger_reg && fault_check_trigger_next && diagCnt_reg == FAULT_CHECK_TRIGGER_END && sense.shorted;
    openFlag_next = fault_check_trigger_reg && fault_check_trigger_next && diagCnt_reg == FAULT_CHECK_TRIGGER_END && sense.open;
    standby_next = coilCurrent_next == CUR_ZERO;
    driveEn_next = !standby_next && !overtempFlag_next && !overcurrentFlag_next;
    image_next.sysCtl = sysCtl_next;
    image_next.curHigh = curHigh_next;
    image_next.curLow = curLow_next;
    image_next.mode = mode_next;
    image_next.status = REG_RESET;
    image_next.status[BIT_FAULT_CHECK_TRIGGER] = fault_check_trigger_next;
    image_next.status[BIT_OVERTEMP] = overtempFlag_next;
    image_next.status[BIT_SHORT] = shortFlag_next;
    image_next.status[BIT_OPEN] = openFlag_next;
    image_next.status[BIT_OVERCURRENT] = overcurrentFlag_next;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrSeen_reg <= 1'b0;
      sysCtl_reg <= REG_RESET;
      curHigh_reg <= REG_RESET;
      curLow_reg <= REG_RESET;
      mode_reg <= REG_RESET;
      fault_check_trigger_reg <= 1'b0;
      shortFlag_reg <= 1'b0;
      openFlag_reg <= 1'b0;
      overtempFlag_reg <= 1'b0;
      overcurrentFlag_reg <= 1'b0;
      diagCnt_reg <= '0;
      retryCnt_reg <= '0;
      coilCurrent_reg <= CUR_ZERO;
      driveEn_reg <= 1'b0;
      standby_reg <= 1'b1;
      image_reg <= '0;
    end else begin
      wrSeen_reg <= wrSeen_next;
      sysCtl_reg <= sysCtl_next;
      curHigh_reg <= curHigh_next;
      curLow_reg <= curLow_next;
      mode_reg <= mode_next;
      fault_check_trigger_reg <= fault_check_trigger_next;
      shortFlag_reg <= shortFlag_next;
      openFlag_reg <= openFlag_next;
      overtempFlag_reg <= overtempFlag_next;
      overcurrentFlag_reg <= overcurrentFlag_next;
      diagCnt_reg <= diagCnt_next;
      retryCnt_reg <= retryCnt_next;
      coilCurrent_reg <= coilCurrent_next;
      driveEn_reg <= driveEn_next;
      standby_reg <= standby_next;
      image_reg <= image_next;
    end
  end

  // Linear code; full scale at all ones, CUR_LSB_NA per step
  assign coilCurrent = coilCurrent_reg;
  assign driveOutPosEn = driveEn_reg;
  assign driveOutNegEn = driveEn_reg;
  assign standby = standby_reg;
  assign diagRun = fault_check_trigger_reg;

  // ---------------- Checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_soft_write;
    softReset;
  endsequence
  property p_soft_reset;
    s_soft_write |=> mode_reg == REG_RESET && coilCurrent_reg == CUR_ZERO && standby_reg
      && sysCtl_reg[BIT_SOFT_RESET];
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset left state");

  property p_current_fields;
    wrApply && wrReq_reg.commit && wrReq_reg.addr == ADDR_CUR_LOW |=>
      coilCurrent_reg == {$past(curHigh_reg[CUR_HIGH_MSB:0]), $past(wrReq_reg.data)};
  endproperty
  a_current_fields: assert property (p_current_fields) else $error("current code mismatch");

  property p_zero_standby;
    coilCurrent_reg == CUR_ZERO |-> standby_reg && !driveOutPosEn && !driveOutNegEn;
  endproperty
  a_zero_standby: assert property (p_zero_standby) else $error("zero code still driving");

  property p_staged_update;
    !(wrApply && wrReq_reg.commit) && !softReset |=> $stable(coilCurrent_reg);
  endproperty
  a_staged_update: assert property (p_staged_update) else $error("code changed without commit");

  sequence s_fault_check_trigger_start;
    wrApply && wrReq_reg.addr == ADDR_STATUS && wrReq_reg.data[BIT_FAULT_CHECK_TRIGGER] && !fault_check_trigger_reg && !softReset;
  endsequence
  property p_fault_check_trigger_delay;
    s_fault_check_trigger_start |=> diagCnt_reg == '0 && !shortFlag_reg && !openFlag_reg ##1 !shortFlag_reg && !openFlag_reg;
  endproperty
  a_fault_check_trigger_delay: assert property (p_fault_check_trigger_delay) else $error("diagnostic result too early");

  property p_overtemp_off;
    overtempFlag_reg |-> !driveOutPosEn && !driveOutNegEn;
  endproperty
  a_overtemp_off: assert property (p_overtemp_off) else $error("driving while hot");

  property p_short_gated;
    !fault_check_trigger_reg |-> !shortFlag_reg;
  endproperty
  a_short_gated: assert property (p_short_gated) else $error("short flag without diagnostic");

  property p_open_gated;
    !fault_check_trigger_reg |-> !openFlag_reg;
  endproperty
  a_open_gated: assert property (p_open_gated) else $error("open flag without diagnostic");

  property p_oc_trip;
    !overcurrentFlag_reg && sense.overcurrent && coilCurrent_reg != CUR_ZERO && !wrApply |=>
      overcurrentFlag_reg && !driveOutPosEn && !driveOutNegEn;
  endproperty
  a_oc_trip: assert property (p_oc_trip) else $error("overcurrent not latched");

  property p_retry;
    overcurrentFlag_reg && mode_reg[BIT_RETRY] && retryCnt_reg == RETRY_END && !sense.overcurrent
      && coilCurrent_reg != CUR_ZERO && !wrApply |=> !overcurrentFlag_reg;
  endproperty
  a_retry: assert property (p_retry) else $error("retry did not resume");

  property p_latched;
    overcurrentFlag_reg && !mode_reg[BIT_RETRY] && coilCurrent_reg != CUR_ZERO && !wrApply
      |=> overcurrentFlag_reg;
  endproperty
  a_latched: assert property (p_latched) else $error("protection released early");

  property p_retry_bit;
    wrApply && wrReq_reg.addr == ADDR_MODE && !softReset |=>
      mode_reg[BIT_RETRY] == $past(wrReq_reg.data[BIT_RETRY]);
  endproperty
  a_retry_bit: assert property (p_retry_bit) else $error("retry enable not stored");

  property p_ptr_advance;
    @(posedge linkClk) disable iff (rst)
      linkState_reg == LINK_WRITE && bitCnt_reg == BIT_LAST && startTog_reg == startSeen_reg
      |=> ptr_reg == $past(ptr_reg) + PTR_STEP;
  endproperty
  a_ptr_advance: assert property (p_ptr_advance) else $error("pointer did not advance");
endmodule
`default_nettype wire

// File: test/ccd_master_model.sv
// Two-wire bus master model: makes the serial clock and drives data open drain.
// Assumes a pull-up on the data line; the clock stands high outside frames.
`timescale 1ns/1ns
`default_nettype none
module ccd_master_model import ccd_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  output logic linkClk,
  output logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe
);
  logic masterOe = 1'b0;
  logic [6:0] target = DEV_ADDR;
  logic ackOk = 1'b0;
  // Pull-up: line low while any party pulls
  assign sdaIn = !(masterOe || (sdaOe && !sdaOut));
  initial linkClk = 1'b1;

  task automatic start();
    masterOe = 1'b0;
    #16 linkClk = 1'b1;
    #16 masterOe = 1'b1;
    #16 linkClk = 1'b0;
  endtask

  task automatic stop();
    #16 masterOe = 1'b1;
    #16 linkClk = 1'b1;
    #16 masterOe = 1'b0;
    #32;
  endtask

  // Eight bits and the acknowledge slot, MSB first; idle gap for the sync
  task automatic xfer(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      #2 masterOe = !d[i];
      #14 linkClk = 1'b1;
      r[i] = sdaIn;
      #16 linkClk = 1'b0;
    end
    #2 masterOe = 1'b0;
    #200;
  endtask

  task automatic write(input logic [7:0] a, input int n, input logic [7:0] d0, input logic [7:0] d1);
    logic [8:0] r;
    start();
    xfer({target, 1'b0, 1'b1}, r);
    ackOk = !r[0];
    xfer({a, 1'b1}, r);
    xfer({d0, 1'b1}, r);
    if (n > 1) xfer({d1, 1'b1}, r);
    stop();
  endtask

  task automatic read(input logic [7:0] a, output logic [7:0] v);
    logic [8:0] r;
    start();
    xfer({target, 1'b0, 1'b1}, r);
    xfer({a, 1'b1}, r);
    start();
    xfer({target, 1'b1, 1'b1}, r);
    // Master NACK ends the read
    xfer(9'h1ff, r);
    v = r[8:1];
    stop();
  endtask
endmodule
`default_nettype wire

// File: test/tb.sv
// Self-checking bench of the coil driver register bank.
// Assumes the two-wire master model and shortened diagnostic and retry counts.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import ccd_pkg::*;
  localparam int FAULT_CHECK_TRIGGER_N = 200;
  localparam int RETRY_N = 50;
  logic clk = 1'b0;
  logic rst = 1'b0;
  logic linkClk, sdaIn, sdaOut, sdaOe;
  logic ocSense = 1'b0;
  logic otSense = 1'b0;
  logic shSense = 1'b0;
  logic opSense = 1'b0;
  logic [9:0] coilCurrent;
  logic driveOutPosEn, driveOutNegEn, standby, diagRun;
  int miscompares = 0;
  int checksDone = 0;
  int cycles = 0;
  logic [7:0] hi, lo;
  logic [9:0] code;

  always #25 clk = ~clk;

  ccd_regs #(.FAULT_CHECK_TRIGGER_COUNT(FAULT_CHECK_TRIGGER_N), .RETRY_COUNT(RETRY_N), .DEV_ADDR(DEV_ADDR_DEFAULT)) ccd_regs_inst (
    .clk(clk), .rst(rst), .linkClk(linkClk), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .overcurrentSense(ocSense), .overtempSense(otSense), .shortSense(shSense), .openSense(opSense),
    .coilCurrent(coilCurrent), .driveOutPosEn(driveOutPosEn), .driveOutNegEn(driveOutNegEn),
    .standby(standby), .diagRun(diagRun));

  ccd_master_model #(.DEV_ADDR(DEV_ADDR_DEFAULT)) ccd_master_model_inst (
    .linkClk(linkClk), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe));

  function automatic logic [9:0] expCode(input logic [7:0] h, input logic [7:0] l);
    return {h[1:0], l};
  endfunction

  function automatic logic [7:0] expStatus(input logic dg, input logic ot, input logic sh, input logic op,
                                           input logic oc);
    logic [7:0] s;
    s = REG_RESET;
    s[BIT_FAULT_CHECK_TRIGGER] = dg;
    s[BIT_OVERTEMP] = ot;
    s[BIT_SHORT] = sh & dg;
    s[BIT_OPEN] = op & dg;
    s[BIT_OVERCURRENT] = oc;
    return s;
  endfunction

  task automatic conclude();
    $display("checks %0d, mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chkReg(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] a);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: register %h read %h, expected %h", $time, a, got, exp);
    end
  endtask

  task automatic chkPin(input logic [9:0] got, input logic [9:0] exp, input string what);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s is %h, expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input int n, input logic [7:0] d0, input logic [7:0] d1);
    ccd_master_model_inst.write(a, n, d0, d1);
    cyc(10);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    ccd_master_model_inst.read(a, v);
    chkReg(v, exp, a);
  endtask

  // Applied code, standby and both drive enables together
  task automatic chkOut(input logic [9:0] c, input logic ok);
    logic on;
    on = ok && (c != CUR_ZERO);
    chkPin(coilCurrent, c, "coil code");
    chkPin({7'h0, standby, driveOutPosEn, driveOutNegEn}, {7'h0, c == CUR_ZERO, on, on}, "drive");
  endtask

  task automatic endTest(input string name);
    $display("test %s done", name);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      $display("wrong value at %0t: run timed out", $time);
      conclude();
    end
  end

  initial begin
    void'($urandom(32'h1d132c47));
    #1 rst = 1'b1;
    cyc(8);
    rst = 1'b0;
    cyc(6);
    chkOut(CUR_ZERO, 1'b0);
    chkPin({9'h0, diagRun}, 10'h000, "fault_check_trigger run");
    for (int a = 2; a <= 7; a++) rdChk(8'(a), REG_RESET);
    endTest("reset");
    for (int i = 0; i < 6; i++) begin
      hi = (i == 0) ? 8'hff : (i == 1) ? 8'hfc : 8'($urandom);
      lo = (i == 0) ? 8'hff : (i == 1) ? 8'h01 : 8'($urandom);
      code = expCode(hi, lo);
      wr(ADDR_CUR_HIGH, 2, hi, lo);
      chkOut(code, 1'b1);
      rdChk(ADDR_CUR_HIGH, hi & CUR_HIGH_MASK);
      rdChk(ADDR_CUR_LOW, lo);
    end
    wr(ADDR_CUR_HIGH, 1, ~hi, 8'h00);
    chkOut(code, 1'b1);
    rdChk(ADDR_CUR_HIGH, ~hi & CUR_HIGH_MASK);
    wr(ADDR_CUR_LOW, 1, ~lo, 8'h00);
    chkOut(code, 1'b1);
    wr(ADDR_CUR_HIGH, 2, 8'h00, 8'h00);
    chkOut(CUR_ZERO, 1'b0);
    endTest("current");
    code = 10'h155;
    wr(ADDR_CUR_HIGH, 2, 8'h01, 8'h55);
    shSense = 1'b1;
    opSense = 1'b1;
    wr(ADDR_STATUS, 1, 8'h3d, 8'h00);
    chkPin({9'h0, diagRun}, 10'h001, "fault_check_trigger run");
    rdChk(ADDR_STATUS, expStatus(1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
    cyc(FAULT_CHECK_TRIGGER_N);
    rdChk(ADDR_STATUS, expStatus(1'b1, 1'b0, 1'b1, 1'b1, 1'b0));
    shSense = 1'b0;
    cyc(10);
    rdChk(ADDR_STATUS, expStatus(1'b1, 1'b0, 1'b0, 1'b1, 1'b0));
    shSense = 1'b1;
    wr(ADDR_STATUS, 1, 8'h00, 8'h00);
    rdChk(ADDR_STATUS, expStatus(1'b0, 1'b0, 1'b1, 1'b1, 1'b0));
    wr(ADDR_STATUS, 1, 8'h20, 8'h00);
    rdChk(ADDR_STATUS, expStatus(1'b1, 1'b0, 1'b0, 1'b0, 1'b0));
    wr(ADDR_STATUS, 1, 8'h00, 8'h00);
    endTest("diagnostic");
    otSense = 1'b1;
    cyc(10);
    chkOut(code, 1'b0);
    rdChk(ADDR_STATUS, expStatus(1'b0, 1'b1, 1'b0, 1'b0, 1'b0));
    otSense = 1'b0;
    cyc(10);
    chkOut(code, 1'b1);
    endTest("overtemp");
    ocSense = 1'b1;
    cyc(10);
    chkOut(code, 1'b0);
    ocSense = 1'b0;
    cyc(3 * RETRY_N);
    chkOut(code, 1'b0);
    rdChk(ADDR_STATUS, expStatus(1'b0, 1'b0, 1'b0, 1'b0, 1'b1));
    wr(ADDR_CUR_HIGH, 2, 8'h00, 8'h00);
    rdChk(ADDR_STATUS, REG_RESET);
    wr(ADDR_CUR_HIGH, 2, 8'h01, 8'h55);
    chkOut(code, 1'b1);
    wr(ADDR_MODE, 1, 8'h80, 8'h00);
    rdChk(ADDR_MODE, 8'h80);
    ocSense = 1'b1;
    cyc(10);
    rdChk(ADDR_STATUS, expStatus(1'b0, 1'b0, 1'b0, 1'b0, 1'b1));
    ocSense = 1'b0;
    cyc(RETRY_N + 10);
    chkOut(code, 1'b1);
    rdChk(ADDR_STATUS, REG_RESET);
    endTest("overcurrent");
    ccd_master_model_inst.target = DEV_ADDR_DEFAULT ^ 7'h01;
    wr(ADDR_CUR_LOW, 1, 8'h00, 8'h00);
    chkPin({9'h0, ccd_master_model_inst.ackOk}, 10'h000, "address ack");
    ccd_master_model_inst.target = DEV_ADDR_DEFAULT;
    chkOut(code, 1'b1);
    wr(8'h07, 1, 8'ha5, 8'h00);
    chkPin({9'h0, ccd_master_model_inst.ackOk}, 10'h001, "address ack");
    rdChk(8'h07, REG_RESET);
    wr(ADDR_SYS_CTL, 1, 8'h03, 8'h00);
    chkOut(CUR_ZERO, 1'b0);
    rdChk(ADDR_SYS_CTL, SOFT_RESET_MASK);
    rdChk(ADDR_MODE, REG_RESET);
    rdChk(ADDR_CUR_LOW, REG_RESET);
    wr(ADDR_SYS_CTL, 1, 8'h00, 8'h00);
    endTest("soft reset");
    conclude();
  end
endmodule
`default_nettype wire
